// [dss_pkg.sv]
// Package for the debug status sticky flag block.
// Assumes a 32-bit APB slave and a single 20 MHz clock.
package dss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] DSS_STATUS_OFS  = 12'h000;
  localparam logic [11:0] DSS_CTRL_OFS    = 12'h004;
  localparam logic [11:0] DSS_IRQ_STS_OFS = 12'h008;
  localparam logic [11:0] DSS_IRQ_EN_OFS  = 12'h00c;
  localparam logic [11:0] DSS_IRQ_CLR_OFS = 12'h010;

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int DSS_MON_DIS_EXT_BIT = 16;
  localparam int DSS_TRC_DIS_EXT_BIT = 15;
  localparam int DSS_TRC_STICKY_BIT  = 13;
  localparam int DSS_TRC_DIS_BIT     = 12;
  localparam int DSS_RESTART_BIT     = 11;
  localparam int DSS_MON_STICKY_BIT  = 10;
  localparam int DSS_MON_DIS_BIT     = 9;
  localparam int DSS_RESET_STS_BIT   = 1;

  // ----------------------------------------------------------------
  // Control register field positions and reset values
  // ----------------------------------------------------------------
  localparam int DSS_CTRL_UNK_BIT   = 0;
  localparam int DSS_CTRL_DLCLR_BIT = 1;
  localparam logic [1:0] DSS_CTRL_RST = 2'h0;
  localparam logic [2:0] DSS_STICKY_RST = 3'h0;
  localparam logic [31:0] DSS_UNKNOWN_DEF = 32'h0000_0000;

  // Interrupt event positions in status, enable and clear registers.
  localparam int DSS_EV_TRC  = 0;
  localparam int DSS_EV_MON  = 1;
  localparam int DSS_EV_RST  = 2;
  localparam int DSS_NEV     = 3;

  typedef struct packed {
    logic       double_lock_active;
    logic       software_lock_active;
    logic       os_lock_active;
    logic       core_domain_powered;
    logic       reset_status_flag;
    logic       trace_access_allowed;
    logic       monitor_access_allowed;
    logic [1:0] trace_world_code;
    logic [1:0] monitor_world_code;
  } dss_state_t;

  typedef struct packed {
    logic trace_err;
    logic monitor_err;
    logic debug_exit;
  } dss_event_t;

endpackage : dss_pkg

// [dss_sticky_bit.sv]
// One sticky flag: set by a hardware event, cleared by a read.
// Assumes set and clear are single-cycle pulses in the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module dss_sticky_bit
  import dss_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);
  logic flag_r;
  logic flag_nxt;

  // Set wins over clear so that no event is lost.
  always_comb begin
    flag_nxt = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_o = flag_r;

  AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
    set_i |=> flag_r) else $error("Sticky flag lost a set.");

endmodule : dss_sticky_bit
`default_nettype wire

// [dss_irq.sv]
// Sticky interrupt status with enable mask and write-one clear.
// Assumes event pulses and a clear vector valid for one pclk cycle.
`timescale 1ns/1ns
`default_nettype none
module dss_irq
  import dss_pkg::*;
#(
  parameter int N = DSS_NEV
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [N-1:0] event_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic [N-1:0] en_i,
  output logic      [N-1:0] status_o,
  output logic              irq_o
);
  logic [N-1:0] status_r;

  initial begin
    if (N < 1) $error("dss_irq needs at least one event.");
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
    end else begin
      status_r <= event_i | (status_r & ~clr_i);
    end
  end

  assign status_o = status_r;
  assign irq_o    = |(status_r & en_i);

endmodule : dss_irq
`default_nettype wire

// [dss_status.sv]
// Debug processor status register with sticky error and restart flags.
// Assumes the debug core drives lock, power and access levels in pclk.
`timescale 1ns/1ns
`default_nettype none
module dss_status
  import dss_pkg::*;
#(
  parameter bit TRACE_FEAT    = 1'b1,
  parameter bit MONITOR_FEAT  = 1'b1,
  parameter bit REALM_FEAT    = 1'b1,
  parameter bit DEBUG_V84     = 1'b1,
  parameter bit POWERDOWN_FEAT = 1'b0,
  parameter bit DLOCK_FEAT    = 1'b1
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire dss_state_t  state_i,
  input  wire dss_event_t  event_i,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The powerdown and double lock features exclude each other in the architecture.
  initial begin
    if (POWERDOWN_FEAT && DLOCK_FEAT) begin
      $error("Powerdown domain and double lock cannot coexist.");
    end
  end

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr_en;
  logic rd_en;
  logic rd_status;
  logic hit;

  assign access    = psel & penable;
  assign wr_en     = access & pwrite;
  assign rd_en     = access & ~pwrite;
  assign rd_status = rd_en & (paddr == DSS_STATUS_OFS);
  assign pready    = 1'b1;

  always_comb begin
    unique case (paddr)
      DSS_STATUS_OFS, DSS_CTRL_OFS, DSS_IRQ_STS_OFS,
      DSS_IRQ_EN_OFS, DSS_IRQ_CLR_OFS: hit = 1'b1;
      default:                         hit = 1'b0;
    endcase
  end

  assign pslverr = access & ~hit;

  // ----------------------------------------------------------------
  // Access conditions
  // ----------------------------------------------------------------
  logic dlock;
  logic unknown;
  logic clear_ok;
  logic ctrl_unk_r;
  logic ctrl_dlclr_r;

  assign dlock = DLOCK_FEAT & state_i.double_lock_active;
  // Fields read as unknown under double lock, pending reset, or no power when the powerdown feature is absent.
  assign unknown = dlock |
                   (!POWERDOWN_FEAT & !state_i.core_domain_powered) |
                   state_i.reset_status_flag;
  // Power is required for a read to clear anything, and a pending
  // reset status keeps the flags as they are.
  assign clear_ok = rd_status & state_i.core_domain_powered &
                    !state_i.reset_status_flag &
                    (!dlock | ctrl_dlclr_r);

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_unk_r   <= DSS_CTRL_RST[DSS_CTRL_UNK_BIT];
      ctrl_dlclr_r <= DSS_CTRL_RST[DSS_CTRL_DLCLR_BIT];
    end else if (wr_en && paddr == DSS_CTRL_OFS && pstrb[0]) begin
      ctrl_unk_r   <= pwdata[DSS_CTRL_UNK_BIT];
      ctrl_dlclr_r <= pwdata[DSS_CTRL_DLCLR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  logic trc_set;
  logic mon_set;
  logic rst_set;
  logic trc_clr;
  logic mon_clr;
  logic rst_clr;
  logic trc_flag;
  logic mon_flag;
  logic rst_flag;
  logic [2:0] seen_r;

  assign trc_set = TRACE_FEAT & event_i.trace_err;
  assign mon_set = MONITOR_FEAT & event_i.monitor_err;
  // Warm reset is seen as a debug exit so the flag marks it too.
  assign rst_set = event_i.debug_exit;
  // Only flags that seen_r caught at the read's setup edge are cleared by it.
  assign trc_clr = clear_ok & seen_r[0];
  // Software lock turns read-clear into a plain read for the monitor and restart flags.
  assign mon_clr = clear_ok & seen_r[1] &
                   !state_i.software_lock_active;
  assign rst_clr = clear_ok & seen_r[2] &
                   !state_i.software_lock_active;

  dss_sticky_bit u_trc (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (trc_set),
    .clr_i   (trc_clr),
    .flag_o  (trc_flag)
  );

  dss_sticky_bit u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (mon_set),
    .clr_i   (mon_clr),
    .flag_o  (mon_flag)
  );

  dss_sticky_bit u_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .set_i   (rst_set),
    .clr_i   (rst_clr),
    .flag_o  (rst_flag)
  );

  // ----------------------------------------------------------------
  // Read snapshot
  // ----------------------------------------------------------------
  // The flags seen at the setup edge are the ones the read reports; a
  // set landing on that same edge must survive until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_r <= DSS_STICKY_RST;
    end else if (psel && !penable && !pwrite) begin
      seen_r <= {rst_flag, mon_flag, trc_flag};
    end
  end

  // ----------------------------------------------------------------
  // Status word assembly
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  logic        mon_unknown;

  // Without the revision feature the OS lock also hides monitor bits.
  assign mon_unknown = unknown |
                       (!DEBUG_V84 & state_i.os_lock_active);

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[DSS_RESET_STS_BIT] = state_i.reset_status_flag;
    status_word[DSS_RESTART_BIT]   = rst_flag;
    if (TRACE_FEAT) begin
      status_word[DSS_TRC_STICKY_BIT] = trc_flag;
      if (REALM_FEAT) begin
        status_word[DSS_TRC_DIS_EXT_BIT] = state_i.trace_world_code[1];
        status_word[DSS_TRC_DIS_BIT]     = state_i.trace_world_code[0];
      end else begin
        status_word[DSS_TRC_DIS_BIT] = !state_i.trace_access_allowed;
      end
    end
    if (MONITOR_FEAT) begin
      status_word[DSS_MON_STICKY_BIT] = mon_flag;
      if (REALM_FEAT) begin
        status_word[DSS_MON_DIS_EXT_BIT] = state_i.monitor_world_code[1];
        status_word[DSS_MON_DIS_BIT]     = state_i.monitor_world_code[0];
      end else begin
        status_word[DSS_MON_DIS_BIT] = !state_i.monitor_access_allowed;
      end
    end
    if (unknown) begin
      status_word[DSS_TRC_STICKY_BIT]  = DSS_UNKNOWN_DEF[DSS_TRC_STICKY_BIT];
      status_word[DSS_TRC_DIS_BIT]     = DSS_UNKNOWN_DEF[DSS_TRC_DIS_BIT];
      status_word[DSS_TRC_DIS_EXT_BIT] = DSS_UNKNOWN_DEF[DSS_TRC_DIS_EXT_BIT];
      status_word[DSS_RESTART_BIT]     = DSS_UNKNOWN_DEF[DSS_RESTART_BIT];
    end
    if (mon_unknown) begin
      status_word[DSS_MON_STICKY_BIT]  = DSS_UNKNOWN_DEF[DSS_MON_STICKY_BIT];
      status_word[DSS_MON_DIS_BIT]     = DSS_UNKNOWN_DEF[DSS_MON_DIS_BIT];
      status_word[DSS_MON_DIS_EXT_BIT] = DSS_UNKNOWN_DEF[DSS_MON_DIS_EXT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [DSS_NEV-1:0] irq_en_r;
  logic [DSS_NEV-1:0] irq_sts;
  logic [DSS_NEV-1:0] irq_clr;
  logic [DSS_NEV-1:0] irq_ev;

  assign irq_ev[DSS_EV_TRC] = trc_set;
  assign irq_ev[DSS_EV_MON] = mon_set;
  assign irq_ev[DSS_EV_RST] = rst_set;
  assign irq_clr = (wr_en && paddr == DSS_IRQ_CLR_OFS && pstrb[0]) ?
                   pwdata[DSS_NEV-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= '0;
    end else if (wr_en && paddr == DSS_IRQ_EN_OFS && pstrb[0]) begin
      irq_en_r <= pwdata[DSS_NEV-1:0];
    end
  end

  dss_irq #(
    .N (DSS_NEV)
  ) u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .event_i  (irq_ev),
    .clr_i    (irq_clr),
    .en_i     (irq_en_r),
    .status_o (irq_sts),
    .irq_o    (irq)
  );

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read data is registered so the answer is stable for the bus.
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (paddr)
      DSS_STATUS_OFS:  rdata_nxt = status_word;
      DSS_CTRL_OFS:    rdata_nxt = {30'h0, ctrl_dlclr_r, ctrl_unk_r};
      DSS_IRQ_STS_OFS: rdata_nxt = {29'h0, irq_sts};
      DSS_IRQ_EN_OFS:  rdata_nxt = {29'h0, irq_en_r};
      default:         rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Captured in setup so the data are valid in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TRC_SET: assert property (@(posedge pclk) disable iff (!presetn)
    trc_set |=> u_trc.flag_r) else $error("Trace flag not set.");
  AST_TRC_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_status && state_i.core_domain_powered && !dlock && !unknown
     && !trc_set && seen_r[0]) |=> !u_trc.flag_r)
    else $error("Trace flag not cleared by read.");
  AST_NO_PWR: assert property (@(posedge pclk) disable iff (!presetn)
    (!state_i.core_domain_powered && !trc_set) |=>
    u_trc.flag_r == $past(u_trc.flag_r))
    else $error("Trace flag changed without power.");
  AST_DL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (dlock && !ctrl_dlclr_r && !trc_set) |=>
    u_trc.flag_r == $past(u_trc.flag_r))
    else $error("Trace flag cleared under double lock.");
  AST_DL_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_status && dlock && ctrl_dlclr_r && state_i.core_domain_powered &&
     !state_i.reset_status_flag && seen_r[0] && !trc_set) |=>
    !u_trc.flag_r)
    else $error("Trace flag kept under double lock clear.");
  AST_UNK_MASK: assert property (@(posedge pclk) disable iff (!presetn)
    unknown |-> status_word[DSS_TRC_STICKY_BIT] ==
    DSS_UNKNOWN_DEF[DSS_TRC_STICKY_BIT])
    else $error("Trace flag shown while unknown.");
  AST_RS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (state_i.reset_status_flag && !trc_set) |=>
    u_trc.flag_r == $past(u_trc.flag_r))
    else $error("Trace flag changed while reset status set.");
  AST_MON_UNK: assert property (@(posedge pclk) disable iff (!presetn)
    unknown |-> status_word[DSS_MON_STICKY_BIT] ==
    DSS_UNKNOWN_DEF[DSS_MON_STICKY_BIT])
    else $error("Monitor flag shown while unknown.");
  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    rst_set |=> rst_flag) else $error("Restart flag not set.");
  AST_RST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_status && state_i.core_domain_powered && !dlock && !unknown &&
     !state_i.software_lock_active && !rst_set && seen_r[2]) |=> !rst_flag)
    else $error("Restart flag not cleared by read.");
  AST_SWLOCK: assert property (@(posedge pclk) disable iff (!presetn)
    (state_i.software_lock_active && !mon_set) |=>
    mon_flag == $past(mon_flag))
    else $error("Monitor flag cleared under lock.");
  AST_MON_SET: assert property (@(posedge pclk) disable iff (!presetn)
    mon_set |=> mon_flag) else $error("Monitor flag not set.");
  AST_SET_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == DSS_STATUS_OFS && trc_set)
    |=> ##1 u_trc.flag_r)
    else $error("Trace set on read setup edge was lost.");
  AST_TRC_CODE: assert property (@(posedge pclk) disable iff (!presetn)
    (!unknown && REALM_FEAT && TRACE_FEAT) |->
    status_word[DSS_TRC_DIS_BIT] == state_i.trace_world_code[0])
    else $error("Trace world code wrong.");
  AST_RESVD: assert property (@(posedge pclk) disable iff (!presetn)
    status_word[31:17] == 15'h0000)
    else $error("Reserved status bits set.");

endmodule : dss_status
`default_nettype wire

// [dss_core_model.sv]
// Behavioural debug core model: drives status levels and event pulses.
// Assumes the bench calls its tasks from the pclk domain.
`timescale 1ns/1ns
`default_nettype none
module dss_core_model
  import dss_pkg::*;
(
  input  wire logic     pclk,
  output var dss_state_t state_o,
  output var dss_event_t event_o
);
  initial begin
    state_o = '0;
    event_o = '0;
  end

  task automatic set_state(input dss_state_t s);
    @(posedge pclk);
    state_o <= s;
  endtask : set_state

  // A warm-reset exit from halt is also reported as a debug_exit pulse.
  // The pulse lasts one cycle, so a stretched event can never be counted twice.
  task automatic pulse(input dss_event_t e);
    @(posedge pclk);
    event_o <= e;
    @(posedge pclk);
    event_o <= '0;
  endtask : pulse
endmodule : dss_core_model
`default_nettype wire

// [tb_debug_status_sticky_flags.sv]
// Bench for the debug status block: APB master, reference model, checks.
// Assumes the package, the design and the core model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_debug_status_sticky_flags
  import dss_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  dss_state_t  st_w;
  dss_event_t  ev;
  dss_state_t  st;
  logic [2:0]  m_f   = '0;
  logic [2:0]  m_irq = '0;
  logic [2:0]  m_en  = '0;
  logic [1:0]  m_ctl = '0;
  logic [31:0] r;
  logic [31:0] rn;
  logic        e;
  int          fails      = 0;
  int          num_checks = 0;
  int          cyc        = 0;

  always #25 pclk = ~pclk;

  dss_core_model i_core (.pclk(pclk), .state_o(st_w), .event_o(ev));

  dss_status i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .state_i(st_w), .event_i(ev), .irq(irq));

  // ------------------------------------------------------------
  // Closing report and hang guard
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Bus master, model and comparison
  // ------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == DSS_CTRL_OFS) m_ctl = d[1:0];
    if (a == DSS_IRQ_EN_OFS) m_en = d[2:0];
    if (a == DSS_IRQ_CLR_OFS) m_irq = m_irq & ~d[2:0];
  endtask : wr

  // Only bits 31:9 are compared; the lower fields, including reset status bit 1, are not modelled.
  task automatic rd_sts(input string s);
    logic [31:0] x;
    x = '0;
    if (!(st.double_lock_active | !st.core_domain_powered |
          st.reset_status_flag)) begin
      x[16] = st.monitor_world_code[1];
      x[15] = st.trace_world_code[1];
      x[13] = m_f[0];
      x[12] = st.trace_world_code[0];
      x[11] = m_f[2];
      x[10] = m_f[1];
      x[9]  = st.monitor_world_code[0];
    end
    apb(1'b0, DSS_STATUS_OFS, '0);
    chk(s, r & 32'hffff_fe00, x);
    if (st.core_domain_powered && !st.reset_status_flag &&
        (!st.double_lock_active || m_ctl[1])) begin
      m_f[0] = 1'b0;
      if (!st.software_lock_active) m_f[2:1] = 2'b00;
    end
  endtask : rd_sts

  function automatic dss_event_t mk(input logic [2:0] v);
    return '{trace_err: v[0], monitor_err: v[1], debug_exit: v[2]};
  endfunction : mk

  task automatic chk_irq();
    @(negedge pclk);
    chk("irq", {31'h0, irq}, {31'h0, |(m_irq & m_en)});
  endtask : chk_irq

  task automatic fire(input logic [2:0] v);
    i_core.pulse(mk(v));
    m_f   = m_f | v;
    m_irq = m_irq | v;
    chk_irq();
  endtask : fire

  task automatic sst();
    i_core.set_state(st);
  endtask : sst

  initial begin
    void'($urandom(32'h09ca));
    st = '0;
    st.core_domain_powered = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    sst();
    apb(1'b0, DSS_CTRL_OFS, '0);
    chk("ctrl", r, 32'h0);
    rd_sts("status after reset");
    for (int i = 0; i < 4; i++) begin
      rn = $urandom();
      st.trace_world_code   = i[1:0];
      st.monitor_world_code = rn[1:0];
      sst();
      rd_sts("world codes");
    end
    wr(DSS_STATUS_OFS, 32'hffff_ffff);
    rd_sts("status write");
    wr(DSS_IRQ_EN_OFS, 32'h7);
    for (int k = 0; k < 4; k++) begin
      rn = $urandom();
      fire(k < 3 ? 3'b001 << k : rn[2:0]);
      rd_sts("flag set");
      rd_sts("flag cleared");
    end
    fire(3'b111);
    st.software_lock_active = 1'b1;
    sst();
    rd_sts("swlock read");
    rd_sts("swlock hold");
    st.software_lock_active = 1'b0;
    sst();
    rd_sts("swlock off");
    for (int c = 0; c < 2; c++) begin
      wr(DSS_CTRL_OFS, c << 1);
      fire(3'b111);
      st.double_lock_active = 1'b1;
      sst();
      rd_sts("dlock read");
      st.double_lock_active = 1'b0;
      sst();
      rd_sts("dlock after");
    end
    for (int j = 0; j < 2; j++) begin
      fire(3'b111);
      st.core_domain_powered = j[0];
      st.reset_status_flag   = j[0];
      sst();
      rd_sts("masked read");
      st.core_domain_powered = 1'b1;
      st.reset_status_flag   = 1'b0;
      sst();
      rd_sts("unmasked read");
    end
    // Events land first in the setup cycle, then in the access cycle.
    for (int d = 0; d < 2; d++) begin
      fork
        rd_sts("read with event");
        begin
          repeat (d) @(posedge pclk);
          i_core.pulse(mk(3'b111));
        end
      join
      m_f   = m_f | 3'b111;
      m_irq = m_irq | 3'b111;
      rd_sts("set wins");
    end
    wr(DSS_IRQ_EN_OFS, 32'h0);
    chk_irq();
    apb(1'b0, DSS_IRQ_STS_OFS, '0);
    chk("irq status", r, {29'h0, m_irq});
    wr(DSS_IRQ_EN_OFS, 32'h2);
    chk_irq();
    wr(DSS_IRQ_CLR_OFS, 32'h5);
    chk_irq();
    wr(DSS_IRQ_CLR_OFS, 32'h7);
    chk_irq();
    apb(1'b0, DSS_IRQ_CLR_OFS, '0);
    chk("irq clear read", r, 32'h0);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    chk("unmapped write err", {31'h0, e}, 32'h1);
    apb(1'b0, 12'h020, '0);
    chk("unmapped read err", {31'h0, e}, 32'h1);
    chk("unmapped read", r, 32'h0);
    fire(3'b111);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    m_f   = '0;
    m_irq = '0;
    m_en  = '0;
    m_ctl = '0;
    apb(1'b0, DSS_IRQ_EN_OFS, '0);
    chk("enable after reset", r, 32'h0);
    rd_sts("status after cold reset");
    chk_irq();
    stop_test();
  end
endmodule : tb_debug_status_sticky_flags
`default_nettype wire
